// >>> wwdt_top.sv
// windowed watchdog timer with an ahb-lite register slave
// assumes a 200 MHz system clock and a 1 kHz oscillator tick on a pin
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - enabled watchdog raises a system reset request when no clear arrives in time
// - counter advances only on the synchronised 1 kHz oscillator tick
// - eleven timeout codes select 8 ms up to 8 s
// - normal or window mode follows only the control register contents
// - in window mode an early clear or a missing clear causes reset
// - every accepted clear restarts the timeout count
// - after enabling window mode the closed period starts on the first clear
// - counting continues in every sleep mode once enabled
// - control writes take effect only after crossing into the tick domain
// - a key write guards changes, and a lock bit freezes the configuration
// - running under a debugger without halt leaves operation unchanged
// - a debug halt stops normal operation while it lasts
// - entering a debug halt clears the counter
// - leaving a halt in window mode first runs one normal timeout
// - period code zero disables, codes one to eleven enable, others reserved
// - nonzero window code enables window mode with the same duration map
// - lock set by software or boot load, cleared by software only in debug mode
// - a clear takes two to three ticks to cross, later clears ignored meanwhile
module wwdt_top
  import wwdt_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // oscillator tick
  input wire logic i_wdt_tick,
  // processor side
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_dbg_mode,
  input wire logic i_dbg_halt,
  // boot configuration load
  input wire logic i_boot_load,
  input wire logic [7:0] i_boot_cfg,
  // reset request
  output logic o_sys_reset_req
);

  // ==========================================================
  // declarations
  logic tick_s;
  logic tick_prev_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [4:0] key_cnt_q;
  logic [4:0] key_cnt_d;
  logic lock_q;
  logic lock_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] act_q;
  logic [7:0] act_d;
  logic ctrl_busy_q;
  logic ctrl_busy_d;
  logic [1:0] ctrl_sync_q;
  logic [1:0] ctrl_sync_d;
  logic clr_busy_q;
  logic clr_busy_d;
  logic [1:0] clr_sync_q;
  logic [1:0] clr_sync_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wwdt_state_e state_q;
  wwdt_state_e state_d;
  logic [CNT_W-1:0] per_ticks;
  logic [CNT_W-1:0] win_ticks;
  logic [CNT_W-1:0] new_per_ticks;
  logic [CNT_W-1:0] new_win_ticks;
  logic per_legal;
  logic win_legal;
  logic new_per_legal;
  logic new_win_legal;

  // ==========================================================
  // oscillator tick crossing and edge detect
  wwdt_sync #(.W(1)) u_tick_sync
  (
    .i_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_d(i_wdt_tick),
    .o_q(tick_s)
  );

  wire tick_en = tick_s & ~tick_prev_q;

  // ==========================================================
  // period decode of active and incoming settings
  wwdt_period #(.LW(CNT_W)) u_per_dec
  (
    .i_code(act_q[CTRL_PER_LSB +: CODE_W]),
    .o_ticks(per_ticks),
    .o_legal(per_legal)
  );

  wwdt_period #(.LW(CNT_W)) u_win_dec
  (
    .i_code(act_q[CTRL_WIN_LSB +: CODE_W]),
    .o_ticks(win_ticks),
    .o_legal(win_legal)
  );

  wwdt_period #(.LW(CNT_W)) u_new_per_dec
  (
    .i_code(i_hwdata[CTRL_PER_LSB +: CODE_W]),
    .o_ticks(new_per_ticks),
    .o_legal(new_per_legal)
  );

  wwdt_period #(.LW(CNT_W)) u_new_win_dec
  (
    .i_code(i_hwdata[CTRL_WIN_LSB +: CODE_W]),
    .o_ticks(new_win_ticks),
    .o_legal(new_win_legal)
  );

  // ==========================================================
  // bus address and data phase decode
  wire addr_take = i_hsel & i_htrans[1] & i_hready;
  wire addr_high_zero = (i_haddr[31:8] == 24'h000000);
  wire wr_ctrl = wr_pend_q & (wr_addr_q == ADDR_CTRL);
  wire wr_status = wr_pend_q & (wr_addr_q == ADDR_STATUS);
  wire wr_key = wr_pend_q & (wr_addr_q == ADDR_KEY);
  wire key_open = (key_cnt_q != 5'h00);
  wire new_codes_ok = new_per_legal & new_win_legal & (new_per_ticks != '0 || new_win_ticks == '0);

  wire ctrl_accept = wr_ctrl & key_open & ~lock_q & ~ctrl_busy_q & new_codes_ok;
  wire lock_set = wr_status & key_open & i_hwdata[STAT_LOCK_BIT];
  wire lock_clr = wr_status & key_open & ~i_hwdata[STAT_LOCK_BIT] & i_dbg_mode;

  wire [31:0] rd_ctrl = {24'h000000, ctrl_q};
  wire [31:0] rd_status = {24'h000000, lock_q, 5'h00, clr_busy_q, ctrl_busy_q};
  wire [31:0] rd_count = {{(32 - CNT_W){1'b0}}, cnt_q};
  wire [7:0] ra = i_haddr[7:0];
  wire [31:0] rd_val = !addr_high_zero ? 32'h00000000 :
                       (ra == ADDR_CTRL) ? rd_ctrl :
                       (ra == ADDR_STATUS) ? rd_status :
                       (ra == ADDR_COUNT) ? rd_count : 32'h00000000;

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;

  // ==========================================================
  // protection key window
  always_comb
  begin
    key_cnt_d = key_cnt_q;
    if (wr_key && i_hwdata[7:0] == PROT_KEY)
      key_cnt_d = PROT_CYCLES;
    else if (wr_ctrl || wr_status)
      key_cnt_d = 5'h00;
    else if (key_open)
      key_cnt_d = key_cnt_q - 5'h01;
  end

  // ==========================================================
  // control register, lock and crossing of settings
  wire ctrl_apply = ctrl_busy_q & tick_en & (ctrl_sync_q == SYNC_LAST_EDGE);
  wire boot_lock = i_boot_cfg[CTRL_PER_LSB +: CODE_W] != CODE_OFF;

  always_comb
  begin
    ctrl_d = ctrl_q;
    act_d = act_q;
    lock_d = lock_q;
    ctrl_busy_d = ctrl_busy_q;
    ctrl_sync_d = ctrl_sync_q;
    if (i_boot_load)
    begin
      ctrl_d = i_boot_cfg;
      act_d = i_boot_cfg;
      lock_d = boot_lock;
      ctrl_busy_d = 1'b0;
      ctrl_sync_d = 2'h0;
    end
    else
    begin
      if (lock_set)
        lock_d = 1'b1;
      else if (lock_clr)
        lock_d = 1'b0;
      if (ctrl_accept)
      begin
        ctrl_d = i_hwdata[7:0];
        ctrl_busy_d = 1'b1;
        ctrl_sync_d = 2'h0;
      end
      else if (ctrl_apply)
      begin
        act_d = ctrl_q;
        ctrl_busy_d = 1'b0;
        ctrl_sync_d = 2'h0;
      end
      else if (ctrl_busy_q && tick_en)
        ctrl_sync_d = ctrl_sync_q + 2'h1;
    end
  end

  // ==========================================================
  // clear request crossing
  wire clr_start = i_watchdog_clear_instruction & ~clr_busy_q;
  wire clr_apply = clr_busy_q & tick_en & (clr_sync_q == SYNC_LAST_EDGE);

  always_comb
  begin
    clr_busy_d = clr_busy_q;
    clr_sync_d = clr_sync_q;
    if (clr_apply)
    begin
      clr_busy_d = 1'b0;
      clr_sync_d = 2'h0;
    end
    else if (clr_start)
    begin
      clr_busy_d = 1'b1;
      clr_sync_d = 2'h0;
    end
    else if (clr_busy_q && tick_en)
      clr_sync_d = clr_sync_q + 2'h1;
  end

  // ==========================================================
  // watchdog state and counter
  wire win_on = (win_ticks != '0) & win_legal;
  wire per_on = (per_ticks != '0) & per_legal;
  wire [CNT_W:0] cnt_next = {1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};
  wire per_done = cnt_next >= {1'b0, per_ticks};
  wire win_done = cnt_next >= {1'b0, win_ticks};
  wire [CNT_W-1:0] cnt_inc = cnt_next[CNT_W-1:0];

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (state_q == ST_FIRE)
      state_d = ST_FIRE;
    else if (ctrl_apply)
    begin
      cnt_d = '0;
      if (ctrl_q[CTRL_PER_LSB +: CODE_W] == CODE_OFF)
        state_d = ST_OFF;
      else if (ctrl_q[CTRL_WIN_LSB +: CODE_W] != CODE_OFF)
        state_d = ST_FIRST;
      else
        state_d = ST_OPEN;
    end
    else if (i_dbg_halt)
    begin
      cnt_d = '0;
      if (state_q != ST_OFF)
        state_d = win_on ? ST_FIRST : ST_OPEN;
    end
    else
    begin
      case (state_q)
        ST_OFF:
        begin
          state_d = per_on ? ST_OPEN : ST_OFF;
          cnt_d = '0;
        end
        ST_FIRST:
        begin
          if (clr_apply)
          begin
            state_d = ST_CLOSED;
            cnt_d = '0;
          end
          else if (tick_en && per_done)
            state_d = ST_FIRE;
          else if (tick_en)
            cnt_d = cnt_inc;
        end
        ST_CLOSED:
        begin
          if (clr_apply)
            state_d = ST_FIRE;
          else if (tick_en && win_done)
          begin
            state_d = ST_OPEN;
            cnt_d = '0;
          end
          else if (tick_en)
            cnt_d = cnt_inc;
        end
        ST_OPEN:
        begin
          if (clr_apply)
          begin
            state_d = win_on ? ST_CLOSED : ST_OPEN;
            cnt_d = '0;
          end
          else if (tick_en && per_done)
            state_d = ST_FIRE;
          else if (tick_en)
            cnt_d = cnt_inc;
        end
        default:
        begin
          state_d = ST_OFF;
          cnt_d = '0;
        end
      endcase
    end
  end

  assign o_sys_reset_req = state_q[4];

  // ==========================================================
  // flip-flops
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tick_prev_q <= 1'b1;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      tick_prev_q <= tick_s;
      wr_pend_q <= addr_take & i_hwrite & addr_high_zero;
      wr_addr_q <= addr_take ? i_haddr[7:0] : wr_addr_q;
      rdata_q <= (addr_take && !i_hwrite) ? rd_val : rdata_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      key_cnt_q <= 5'h00;
      lock_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      act_q <= CTRL_RESET;
      ctrl_busy_q <= 1'b0;
      ctrl_sync_q <= 2'h0;
    end
    else
    begin
      key_cnt_q <= key_cnt_d;
      lock_q <= lock_d;
      ctrl_q <= ctrl_d;
      act_q <= act_d;
      ctrl_busy_q <= ctrl_busy_d;
      ctrl_sync_q <= ctrl_sync_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      clr_busy_q <= 1'b0;
      clr_sync_q <= 2'h0;
      cnt_q <= '0;
      state_q <= ST_OFF;
    end
    else
    begin
      clr_busy_q <= clr_busy_d;
      clr_sync_q <= clr_sync_d;
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

endmodule

// >>> wwdt_pkg.sv
// package of constants for the windowed watchdog timer
// assumes one system clock and a 1 kHz tick arriving on a pin
package wwdt_pkg;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_KEY = 8'h02;
  localparam logic [7:0] IDX_COUNT = 8'h03;
  localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL << 2);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS << 2);
  localparam logic [7:0] ADDR_KEY = 8'(IDX_KEY << 2);
  localparam logic [7:0] ADDR_COUNT = 8'(IDX_COUNT << 2);

  // ==========================================================
  // field positions and reset values
  localparam int CTRL_PER_LSB = 0;
  localparam int CTRL_WIN_LSB = 4;
  localparam int CODE_W = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CLR_BIT = 1;
  localparam int STAT_LOCK_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // timing: codes, tick counts, synchronisation, protection
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hB;
  localparam int BASE_TICKS = 8;
  localparam int CNT_W = 14;
  localparam logic [1:0] SYNC_LAST_EDGE = 2'h2;
  localparam logic [7:0] PROT_KEY = 8'hA5;
  localparam logic [4:0] PROT_CYCLES = 5'h10;

  // ==========================================================
  // watchdog states
  typedef enum logic [4:0]
  {
    ST_OFF = 5'b00001,
    ST_FIRST = 5'b00010,
    ST_CLOSED = 5'b00100,
    ST_OPEN = 5'b01000,
    ST_FIRE = 5'b10000
  } wwdt_state_e;

endpackage

// >>> wwdt_sync.sv
// two flip-flop level synchroniser
// assumes the input is a level from another clock
`timescale 1ns/1ps
module wwdt_sync
  import wwdt_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // level in and out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule

// >>> wwdt_period.sv
// decode of a period code into a count of watchdog ticks
// assumes codes above the top code are reserved
`timescale 1ns/1ps
module wwdt_period
  import wwdt_pkg::*;
#(
  parameter int LW = CNT_W
)
(
  // code in
  input wire logic [CODE_W-1:0] i_code,
  // ticks out
  output logic [LW-1:0] o_ticks,
  output logic o_legal
);

  wire is_off = (i_code == CODE_OFF);

  assign o_legal = (i_code <= CODE_MAX);
  assign o_ticks = (is_off || !o_legal) ? '0 : (LW'(BASE_TICKS) << (i_code - 4'h1));

endmodule

// >>> wwdt_cpu_model.sv
// processor model that issues watchdog clears
// assumes the bench asks for each clear with a go strobe
`timescale 1ns/1ps
module wwdt_cpu_model
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // request and clear pulse
  input wire logic i_go,
  output logic o_clear
);
  // ==========
  // one single-cycle clear per request
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      o_clear <= 1'b0;
    else
      o_clear <= i_go && !o_clear;
endmodule

// >>> wwdt_monitor.sv
// checker on the watchdog top ports
// assumes it is bound into wwdt_top
`timescale 1ns/1ps
module wwdt_monitor
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  // watchdog
  input wire logic i_wdt_tick,
  input wire logic i_dbg_halt,
  input wire logic o_sys_reset_req
);
  // ==========
  // read address phase taken
  wire rd_ph = i_hsel && i_htrans[1] && !i_hwrite && i_hready;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  ready_high_a: assert property (o_hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!o_hresp)
    else $error("hresp not okay");
  upper_zero_a: assert property (o_hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_zero_a: assert property (rd_ph && i_haddr > 32'h0000000C |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  req_sticky_a: assert property (o_sys_reset_req |=> o_sys_reset_req)
    else $error("reset request dropped");
  tick_cause_a: assert property ($rose(o_sys_reset_req) |-> $past(i_wdt_tick, 2))
    else $error("reset request without tick");
  halt_quiet_a: assert property (i_dbg_halt && $past(i_dbg_halt, 4) |-> !$rose(o_sys_reset_req))
    else $error("reset request during halt");
  halt_count_a: assert property (rd_ph && i_haddr == 32'h0000000C && i_dbg_halt && $past(i_dbg_halt, 2)
    |=> o_hrdata == 32'h0)
    else $error("count not zero in halt");
endmodule
bind wwdt_top wwdt_monitor u_mon (.i_ref_clk, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready,
  .o_hreadyout, .o_hresp, .o_hrdata, .i_wdt_tick, .i_dbg_halt, .o_sys_reset_req);

// >>> windowed_watchdog_timer_bench.sv
// testbench for the windowed watchdog timer
// assumes package, design, model and checker compiled first
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
  import wwdt_pkg::*;
  // ==========
  // signals
  logic i_ref_clk = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, i_hready, o_hreadyout, o_hresp;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata;
  logic [1:0] i_htrans = 0;
  logic [2:0] i_hsize = 3'h2;
  logic i_wdt_tick = 0, i_watchdog_clear_instruction, i_dbg_mode = 0, i_dbg_halt = 0;
  logic i_boot_load = 0, cpu_go = 0, o_sys_reset_req;
  logic [7:0] i_boot_cfg = 8'h11;
  logic [4:0] tc = 0;
  int fails = 0, n_tests = 0;
  assign i_hready = o_hreadyout;
  always #2.5 i_ref_clk = ~i_ref_clk;
  // tick of 40 clock cycles
  always @(posedge i_ref_clk)
  begin
    tc <= (tc == 5'd19) ? 5'd0 : tc + 5'd1;
    if (tc == 5'd19)
      i_wdt_tick <= ~i_wdt_tick;
  end
  wwdt_top u_dut (.i_ref_clk, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready,
    .o_hreadyout, .o_hresp, .o_hrdata, .i_wdt_tick, .i_watchdog_clear_instruction, .i_dbg_mode, .i_dbg_halt,
    .i_boot_load, .i_boot_cfg, .o_sys_reset_req);
  wwdt_cpu_model u_cpu (.i_clk(i_ref_clk), .i_rstn, .i_go(cpu_go), .o_clear(i_watchdog_clear_instruction));
  // ==========
  // tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    do @(posedge i_ref_clk); while (i_hready !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_ref_clk); while (i_hready !== 1'b1);
    r = o_hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h0, d}, r);
  endtask
  task kw(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_KEY, PROT_KEY);
    wr(a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, {24'h0, e});
  endtask
  task tk(input int n);
    repeat (n * 40) @(posedge i_ref_clk);
  endtask
  task clr;
    cpu_go <= 1'b1;
    @(posedge i_ref_clk);
    cpu_go <= 1'b0;
  endtask
  task rq(input logic e);
    chk({31'h0, o_sys_reset_req}, {31'h0, e});
  endtask
  // cycles until reset request must fall in lo..hi
  task wrq(input int lo, input int hi);
    int n;
    n = 0;
    while (o_sys_reset_req !== 1'b1 && n < hi)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    chk({31'h0, n >= lo && n < hi}, 32'h1);
  endtask
  task rst;
    i_rstn <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    @(posedge i_ref_clk);
  endtask
  // ==========
  // scenarios
  task t_regs;
    rd(ADDR_CTRL, CTRL_RESET);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h00);
    kw(ADDR_CTRL, 8'h0C);
    rd(ADDR_CTRL, 8'h00);
    kw(ADDR_CTRL, 8'h10);
    rd(ADDR_CTRL, 8'h00);
    wr(8'h10, 8'h01);
    rd(8'h10, 8'h00);
    kw(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS, 8'h80);
    kw(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h00);
    rst;
    $display("t_regs done");
  endtask
  task t_normal;
    kw(ADDR_CTRL, 8'h01);
    rd(ADDR_STATUS, 8'h01);
    kw(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, 8'h01);
    tk(4);
    rd(ADDR_STATUS, 8'h00);
    clr;
    @(posedge i_ref_clk);
    rd(ADDR_STATUS, 8'h02);
    tk(3);
    repeat (3)
    begin
      clr;
      tk(4);
    end
    rq(1'b0);
    wrq(200, 360);
    rst;
    $display("t_normal done");
  endtask
  task t_window;
    kw(ADDR_CTRL, 8'h11);
    tk(4);
    clr;
    tk(13);
    rq(1'b0);
    clr;
    tk(5);
    rq(1'b0);
    clr;
    wrq(40, 200);
    rst;
    $display("t_window done");
  endtask
  task t_halt;
    i_boot_load <= 1'b1;
    @(posedge i_ref_clk);
    i_boot_load <= 1'b0;
    rd(ADDR_STATUS, 8'h80);
    kw(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h11);
    kw(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    i_dbg_mode <= 1'b1;
    i_dbg_halt <= 1'b1;
    tk(20);
    rq(1'b0);
    rd(ADDR_COUNT, 8'h00);
    kw(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    i_dbg_halt <= 1'b0;
    tk(3);
    clr;
    tk(6);
    rq(1'b0);
    wrq(400, 640);
    rst;
    $display("t_halt done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // main sequence and watchdog
  initial
  begin
    rst;
    t_regs;
    t_normal;
    t_window;
    t_halt;
    print_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    fails++;
    print_verdict;
  end
endmodule
